/* File: flash_id_device.sv */
// device end: serial number and parameter table read over the flash link
`timescale 1ns/1ns
`default_nettype none
module flash_id_device #(
  parameter logic [127:0] UNIQUE_ID = 128'h0123456789ABCDEF_FEDCBA9876543210,
  // arbitrary value
  parameter logic [7:0]   VENDOR_ID = 8'h5C
) (
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  flash_link_if.device     link,
  output logic             busy_out,
  output logic [7:0]       opcode_out
);
  typedef enum logic [2:0] {
    D_IDLE,
    D_CMD,
    D_ADDR,
    D_DUMMY,
    D_DATA,
    D_IGNORE
  } dev_state_t;

  // byte lookup over the parameter tables
  function automatic logic [7:0] table_byte(input logic [23:0] a, input logic [7:0] vid);
    logic [23:0] off;
    off = a - flash_id_pkg::JEDEC_BASE;
    if (a == flash_id_pkg::VENDOR_ID_OFFSET)
      table_byte = vid;
    else if (a < flash_id_pkg::HDR_LEN)
      table_byte = flash_id_pkg::HDR_BYTES[a[4:0]];
    else if (a >= flash_id_pkg::JEDEC_BASE && off < flash_id_pkg::JEDEC_LEN)
      table_byte = flash_id_pkg::JEDEC_BYTES[off[3:0]];
    else
      table_byte = flash_id_pkg::FILL_BYTE;
  endfunction : table_byte

  dev_state_t  state;
  logic        sclk_s1;
  logic        sclk_s2;
  logic        sclk_d;
  logic        cs_s1;
  logic        cs_s2;
  logic        mosi_s1;
  logic        mosi_s2;
  logic [7:0]  in_shift;
  logic [5:0]  cnt;
  logic [5:0]  dummy_last;
  logic [23:0] addr;
  logic        is_serial;
  logic [7:0]  buf_mem [0:1];
  logic        wr_ptr;
  logic        rd_ptr;
  logic [1:0]  count;
  logic [7:0]  out_shift;
  logic [2:0]  out_cnt;
  logic        miso_q;

  wire logic         rise;
  wire logic         fall;
  wire logic         cs_low;
  wire logic [7:0]   next_in;
  wire logic [5:0]   phase_last;
  wire logic         bit_done;
  wire logic [127:0] uid_shifted;
  wire logic [7:0]   fetch_byte;
  wire logic         serial_spent;
  wire logic         buf_in_ready;
  wire logic         buf_out_valid;
  wire logic         push;
  wire logic         pop;
  wire logic         load_now;
  wire logic [7:0]   load_byte;
  wire logic [1:0]   next_count;

  // two-flop synchronisers for the link pins
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_d  <= 1'b0;
      cs_s1   <= 1'b1;
      cs_s2   <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
    end
    else
    begin
      sclk_s1 <= link.sclk;
      sclk_s2 <= sclk_s1;
      sclk_d  <= sclk_s2;
      cs_s1   <= link.cs_n;
      cs_s2   <= cs_s1;
      mosi_s1 <= link.mosi;
      mosi_s2 <= mosi_s1;
    end
  end

  assign rise       = sclk_s2 & ~sclk_d;
  assign fall       = ~sclk_s2 & sclk_d;
  assign cs_low     = ~cs_s2;
  assign next_in    = {in_shift[6:0], mosi_s2};
  assign phase_last = (state == D_CMD)  ? 6'(flash_id_pkg::CMD_BITS - 1) :
                      (state == D_ADDR) ? 6'(flash_id_pkg::ADDR_BITS - 1) : dummy_last;
  assign bit_done   = rise && (cnt == phase_last);

  // identifier is a fixed constant, no write path exists
  assign uid_shifted  = UNIQUE_ID << {addr[3:0], 3'b000};
  assign serial_spent = is_serial && (addr >= 24'(flash_id_pkg::ID_BYTES));
  assign fetch_byte   = is_serial ? uid_shifted[127:120] : table_byte(addr, VENDOR_ID);

  assign buf_in_ready  = (count != 2'h2);
  assign buf_out_valid = (count != 2'h0);
  assign push          = (state == D_DATA) && buf_in_ready && !serial_spent;
  assign load_now      = fall && (state == D_DATA) && (out_cnt == 3'h0);
  assign pop           = load_now && buf_out_valid;
  assign load_byte     = buf_out_valid ? buf_mem[rd_ptr] : flash_id_pkg::FILL_BYTE;
  assign next_count    = 2'(count + {1'b0, push} - {1'b0, pop});

  // command, address and dummy phases
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state      <= D_IDLE;
      cnt        <= 6'h00;
      in_shift   <= 8'h00;
      dummy_last <= 6'h00;
      addr       <= 24'h000000;
      is_serial  <= 1'b0;
      opcode_out <= 8'h00;
    end
    else if (!cs_low)
    begin
      state <= D_IDLE;
      cnt   <= 6'h00;
    end
    else
    begin
      case (state)
        D_IDLE:
          state <= D_CMD;
        D_CMD, D_ADDR, D_DUMMY:
        begin
          if (rise)
          begin
            in_shift <= next_in;
            cnt      <= bit_done ? 6'h00 : 6'(cnt + 6'h01);
            if (state == D_ADDR)
              addr <= {addr[22:0], mosi_s2};
          end
          if (bit_done && state == D_CMD)
          begin
            opcode_out <= next_in;
            if (next_in == flash_id_pkg::OP_SERIAL)
            begin
              state      <= D_DUMMY;
              is_serial  <= 1'b1;
              addr       <= 24'h000000;
              dummy_last <= 6'(flash_id_pkg::SERIAL_DUMMY_BYTES * 8 - 1);
            end
            else if (next_in == flash_id_pkg::OP_TABLE)
            begin
              state      <= D_ADDR;
              is_serial  <= 1'b0;
              dummy_last <= 6'(flash_id_pkg::TABLE_DUMMY_BYTES * 8 - 1);
            end
            else
              state <= D_IGNORE;
          end
          else if (bit_done && state == D_ADDR)
            state <= D_DUMMY;
          else if (bit_done)
            state <= D_DATA;
        end
        D_DATA:
          if (push)
            addr <= 24'(addr + 24'h000001);
        D_IGNORE:
          state <= D_IGNORE;
        default:
          state <= D_IDLE;
      endcase
    end
  end

  // two-entry byte buffer between table lookup and shifter
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      buf_mem[0] <= 8'hFF;
      buf_mem[1] <= 8'hFF;
      wr_ptr     <= 1'b0;
      rd_ptr     <= 1'b0;
      count      <= 2'h0;
    end
    else if (!cs_low)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        buf_mem[wr_ptr] <= fetch_byte;
        wr_ptr          <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      count <= next_count;
    end
  end

  // output shifter, new bit on each falling serial clock
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      miso_q    <= 1'b1;
      out_shift <= 8'hFF;
      out_cnt   <= 3'h0;
    end
    else if (!cs_low)
    begin
      miso_q    <= 1'b1;
      out_shift <= 8'hFF;
      out_cnt   <= 3'h0;
    end
    else if (fall && state == D_DATA)
    begin
      if (load_now)
      begin
        miso_q    <= load_byte[7];
        out_shift <= {load_byte[6:0], 1'b1};
        out_cnt   <= 3'h7;
      end
      else
      begin
        miso_q    <= out_shift[7];
        out_shift <= {out_shift[6:0], 1'b1};
        out_cnt   <= 3'(out_cnt - 3'h1);
      end
    end
  end

  assign link.miso_o    = miso_q;
  assign link.miso_oe_n = (state != D_DATA);
  assign busy_out       = (state != D_IDLE);

endmodule : flash_id_device
`default_nettype wire

/* File: flash_id_host.sv */
// host end: issues serial number and parameter table reads on the flash link
`timescale 1ns/1ns
`default_nettype none
module flash_id_host #(
  parameter int HALF_CYCLES = flash_id_pkg::HALF_CYCLES
) (
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  flash_link_if.host       link,
  input  wire logic        start_in,
  input  wire logic        serial_cmd_in,
  input  wire logic [23:0] addr_in,
  input  wire logic [7:0]  len_in,
  output logic             busy_out,
  output logic             done_out,
  output logic [7:0]       data_out,
  output logic             data_valid_out,
  input  wire logic        data_ready_in
);

  if (HALF_CYCLES < 4 || HALF_CYCLES > 255)
  begin : g_half_check
    $error("HALF_CYCLES must lie in 4..255");
  end

  typedef enum logic [1:0] {
    H_IDLE,
    H_SELECT,
    H_SHIFT,
    H_DESELECT
  } host_state_t;

  host_state_t state;
  logic        sclk_q;
  logic        cs_n_q;
  logic        mosi_q;
  logic [7:0]  div;
  logic [39:0] tx;
  logic [7:0]  rx;
  logic [2:0]  bit_cnt;
  logic [8:0]  byte_cnt;
  logic [8:0]  total;
  logic        miso_s1;
  logic        miso_s2;
  logic [7:0]  buf_mem [0:1];
  logic        wr_ptr;
  logic        rd_ptr;
  logic [1:0]  count;

  wire logic        tick;
  wire logic        data_byte;
  wire logic        stall;
  wire logic [39:0] tx_init;
  wire logic [7:0]  rx_byte;
  wire logic        push;
  wire logic        pop;
  wire logic        buf_in_ready;

  assign tick         = (div == 8'(HALF_CYCLES - 1));
  assign data_byte    = (byte_cnt >= 9'(flash_id_pkg::HEADER_BYTES));
  assign buf_in_ready = (count != 2'h2);
  assign stall        = data_byte && (bit_cnt == 3'h7) && !buf_in_ready;
  assign tx_init      = serial_cmd_in ? {flash_id_pkg::OP_SERIAL, 32'h00000000} :
                                        {flash_id_pkg::OP_TABLE, addr_in, 8'h00};
  assign rx_byte      = {rx[6:0], miso_s2};
  assign push         = (state == H_SHIFT) && tick && sclk_q && data_byte && (bit_cnt == 3'h7);
  assign pop          = data_valid_out && data_ready_in;

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      miso_s1 <= 1'b1;
      miso_s2 <= 1'b1;
    end
    else
    begin
      miso_s1 <= link.miso;
      miso_s2 <= miso_s1;
    end
  end

  // clock divider, half a link period per tick
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      div <= 8'h00;
    else if (tick || state == H_IDLE)
      div <= 8'h00;
    else
      div <= 8'(div + 8'h01);
  end

  // transfer sequencer
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state    <= H_IDLE;
      sclk_q   <= 1'b0;
      cs_n_q   <= 1'b1;
      mosi_q   <= 1'b0;
      tx       <= 40'h0000000000;
      rx       <= 8'h00;
      bit_cnt  <= 3'h0;
      byte_cnt <= 9'h000;
      total    <= 9'h000;
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      case (state)
        H_IDLE:
        begin
          if (start_in)
          begin
            cs_n_q   <= 1'b0;
            mosi_q   <= tx_init[39];
            tx       <= {tx_init[38:0], 1'b0};
            bit_cnt  <= 3'h0;
            byte_cnt <= 9'h000;
            total    <= serial_cmd_in ? 9'(flash_id_pkg::HEADER_BYTES + flash_id_pkg::ID_BYTES)
                                      : 9'(flash_id_pkg::HEADER_BYTES + len_in);
            state    <= H_SELECT;
          end
        end
        H_SELECT:
        begin
          if (tick)
            state <= H_SHIFT;
        end
        H_SHIFT:
        begin
          if (tick && !sclk_q && !stall)
            sclk_q <= 1'b1;
          else if (tick && sclk_q)
          begin
            sclk_q  <= 1'b0;
            rx      <= rx_byte;
            mosi_q  <= tx[39];
            tx      <= {tx[38:0], 1'b0};
            bit_cnt <= 3'(bit_cnt + 3'h1);
            if (bit_cnt == 3'h7)
            begin
              byte_cnt <= 9'(byte_cnt + 9'h001);
              if (9'(byte_cnt + 9'h001) == total)
              begin
                cs_n_q <= 1'b1;
                state  <= H_DESELECT;
              end
            end
          end
        end
        H_DESELECT:
        begin
          mosi_q <= 1'b0;
          if (tick)
          begin
            done_out <= 1'b1;
            state    <= H_IDLE;
          end
        end
        default:
        begin
          state <= H_IDLE;
        end
      endcase
    end
  end

  // two-entry buffer toward the user; a full buffer holds the link clock
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      buf_mem[0] <= 8'h00;
      buf_mem[1] <= 8'h00;
      wr_ptr     <= 1'b0;
      rd_ptr     <= 1'b0;
      count      <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        buf_mem[wr_ptr] <= rx_byte;
        wr_ptr          <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      count <= 2'(count + {1'b0, push} - {1'b0, pop});
    end
  end

  assign data_out       = buf_mem[rd_ptr];
  assign data_valid_out = (count != 2'h0);
  assign busy_out       = (state != H_IDLE);
  assign link.sclk      = sclk_q;
  assign link.cs_n      = cs_n_q;
  assign link.mosi      = mosi_q;

endmodule : flash_id_host
`default_nettype wire

/* File: flash_id_pkg.sv */
// shared constants for the serial number and parameter table read logic
package flash_id_pkg;

  // command opcodes
  localparam logic [7:0]  OP_SERIAL          = 8'h4B;
  localparam logic [7:0]  OP_TABLE           = 8'h5A;

  // phase lengths
  localparam int          CMD_BITS           = 8;
  localparam int          ADDR_BITS          = 24;
  localparam int          SERIAL_DUMMY_BYTES = 4;
  localparam int          TABLE_DUMMY_BYTES  = 1;
  localparam int          HEADER_BYTES       = 5;
  localparam int          ID_BITS            = 128;
  localparam int          ID_BYTES           = 16;

  // table layout
  localparam logic [7:0]  FILL_BYTE          = 8'hFF;
  localparam logic [23:0] HDR_LEN            = 24'h000018;
  localparam logic [23:0] VENDOR_ID_OFFSET   = 24'h000010;
  localparam logic [23:0] JEDEC_BASE         = 24'h000030;
  localparam logic [23:0] JEDEC_LEN          = 24'h00000C;

  // table header and two parameter headers, vendor id slot patched at run time
  localparam logic [7:0] HDR_BYTES [0:23] = '{
    8'h53, 8'h46, 8'h44, 8'h50,
    8'h00, 8'h01,
    8'h01,
    8'hFF,
    8'h00, 8'h00, 8'h01, 8'h09,
    8'h30, 8'h00, 8'h00,
    8'hFF,
    8'h00, 8'h00, 8'h01, 8'h03,
    8'h60, 8'h00, 8'h00,
    8'hFF
  };

  // first standard parameter dwords, density left at fill
  localparam logic [7:0] JEDEC_BYTES [0:11] = '{
    8'hE5, 8'h20,
    8'hF9, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'h44, 8'hEB,
    8'h08, 8'h6B
  };

  // link timing
  localparam int          CLK_PERIOD_NS      = 20;
  localparam int          LINK_PERIOD_NS     = 160;
  localparam int          HALF_CYCLES        = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

endpackage : flash_id_pkg

/* File: flash_link_if.sv */
// serial flash link between host controller and identification logic
`timescale 1ns/1ns
`default_nettype none
interface flash_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso_o;
  logic miso_oe_n;
  logic miso;

  // released output line reads high through a pull-up
  assign miso = miso_oe_n ? 1'b1 : miso_o;

  modport device (input sclk, input cs_n, input mosi, output miso_o, output miso_oe_n);
  modport host   (output sclk, output cs_n, output mosi, input miso);
endinterface : flash_link_if
`default_nettype wire

/* File: unique_id_and_sfdp_read_assertions.sv */
// concurrent checks on the flash link between host and device ends
`timescale 1ns/1ns
`default_nettype none
module unique_id_and_sfdp_read_assertions (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe_n,
  input wire logic miso
);
  logic        sclk_d;
  logic [15:0] rise_cnt;
  wire logic   sclk_rise = sclk && !sclk_d;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);

  // rising serial clock edges seen in the current frame
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      sclk_d <= 1'b0;
    else
      sclk_d <= sclk;
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      rise_cnt <= 16'h0000;
    else if (cs_n)
      rise_cnt <= 16'h0000;
    else if (sclk_rise)
      rise_cnt <= rise_cnt + 16'h0001;
  end

  sequence s_high_phase;
    sclk [*4] ##1 !sclk;
  endsequence

  sequence s_released;
    ##[0:6] miso_oe_n;
  endsequence

  property p_idle_low;
    cs_n && $past(cs_n) |-> !sclk;
  endproperty
  property p_half_period;
    $rose(sclk) |-> s_high_phase;
  endproperty
  property p_mosi_hold;
    sclk && $past(sclk) |-> $stable(mosi);
  endproperty
  property p_cs_edge;
    $changed(cs_n) |-> !sclk;
  endproperty
  property p_no_early_drive;
    $fell(cs_n) |-> miso_oe_n [*8];
  endproperty
  property p_release;
    $rose(cs_n) |-> s_released;
  endproperty
  property p_stay_released;
    cs_n [*8] |-> miso_oe_n && miso_o && miso;
  endproperty
  property p_hold_data;
    !miso_oe_n && !$past(miso_oe_n) && sclk && $past(sclk) |-> $stable(miso_o);
  endproperty
  property p_header_len;
    $fell(miso_oe_n) |-> rise_cnt == 16'h0028;
  endproperty
  property p_frame_len;
    $rose(cs_n) |-> (rise_cnt >= 16'h0028) && (rise_cnt[2:0] == 3'h0);
  endproperty

  a_idle_low: assert property (p_idle_low)
    else $error("serial clock high while deselected");
  a_half_period: assert property (p_half_period)
    else $error("serial clock high phase length wrong");
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("input line changed while clock high");
  a_cs_edge: assert property (p_cs_edge)
    else $error("chip select moved while clock high");
  a_no_early_drive: assert property (p_no_early_drive)
    else $error("output driven during opcode");
  a_release: assert property (p_release)
    else $error("output not released after deselect");
  a_stay_released: assert property (p_stay_released)
    else $error("output driven while deselected");
  a_hold_data: assert property (p_hold_data)
    else $error("output bit changed while clock high");
  a_header_len: assert property (p_header_len)
    else $error("output started after wrong header length");
  a_frame_len: assert property (p_frame_len)
    else $error("frame not whole bytes");
endmodule : unique_id_and_sfdp_read_assertions
`default_nettype wire

/* File: unique_id_and_sfdp_read_tb.sv */
// self-checking bench for the serial number and parameter table read ends
`timescale 1ns/1ns
`default_nettype none
module unique_id_and_sfdp_read_tb;
  localparam logic [127:0] UID = 128'hA5C31E770F429BD86E21C0FF3B94D75A;  // arbitrary value
  localparam logic [7:0]   VID = 8'h3E;  // arbitrary value
  localparam logic [7:0]   HDR [0:23] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01,
    8'hFF, 8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h01,
    8'h03, 8'h60, 8'h00, 8'h00, 8'hFF};
  localparam logic [7:0]   JED [0:11] = '{8'hE5, 8'h20, 8'hF9, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'h44, 8'hEB, 8'h08, 8'h6B};
  logic        clk_sys_in    = 1'b0;
  logic        sys_rst_in    = 1'b1;
  logic        start_in      = 1'b0;
  logic        serial_cmd_in = 1'b0;
  logic [23:0] addr_in       = 24'h000000;
  logic [7:0]  len_in        = 8'h00;
  logic        data_ready_in = 1'b0;
  logic        host_busy;
  logic        done;
  logic        data_valid;
  logic        dev_busy;
  logic [7:0]  data;
  logic [7:0]  dev_opcode;
  logic [7:0]  rx_q [$];
  int          ready_pct     = 70;
  int          miscompares   = 0;
  int          n_checks      = 0;

  flash_link_if link ();
  flash_id_device #(.UNIQUE_ID(UID), .VENDOR_ID(VID)) i_flash_id_device (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .link(link.device),
    .busy_out(dev_busy), .opcode_out(dev_opcode));
  flash_id_host #(.HALF_CYCLES(4)) i_flash_id_host (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .link(link.host), .start_in(start_in),
    .serial_cmd_in(serial_cmd_in), .addr_in(addr_in), .len_in(len_in), .busy_out(host_busy),
    .done_out(done), .data_out(data), .data_valid_out(data_valid),
    .data_ready_in(data_ready_in));
  unique_id_and_sfdp_read_assertions u_chk (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .sclk(link.sclk), .cs_n(link.cs_n),
    .mosi(link.mosi), .miso_o(link.miso_o), .miso_oe_n(link.miso_oe_n), .miso(link.miso));

  always #(flash_id_pkg::CLK_PERIOD_NS / 2) clk_sys_in = ~clk_sys_in;

  // random receiver stalls, and collection of every accepted byte
  always @(posedge clk_sys_in)
  begin
    data_ready_in <= ($urandom_range(99) < ready_pct);
    if (data_valid === 1'b1 && data_ready_in === 1'b1)
      rx_q.push_back(data);
  end

  function automatic logic [7:0] exp_byte(input logic ser, input int idx, input logic [23:0] a);
    if (ser)
      return (idx < 16) ? UID[127 - 8 * idx -: 8] : 8'hFF;
    if (a == 24'h000010)
      return VID;
    if (a < 24'h000018)
      return HDR[a[4:0]];
    if (a >= 24'h000030 && a < 24'h00003C)
      return JED[a[3:0]];
    return 8'hFF;
  endfunction : exp_byte

  // host-side reading of the wait and mode fields of a fast read byte
  function automatic logic wait_ok(input logic [7:0] b);
    return (b[4:0] != 5'h00);
  endfunction : wait_ok

  function automatic logic mode_ok(input logic [7:0] b);
    return (b[7:5] != 3'h0);
  endfunction : mode_ok

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic run_read(input logic ser, input logic [23:0] a, input logic [7:0] n);
    int k;
    rx_q.delete();
    repeat (10) @(posedge clk_sys_in);
    serial_cmd_in <= ser;
    addr_in       <= a;
    len_in        <= n;
    start_in      <= 1'b1;
    @(posedge clk_sys_in);
    start_in      <= 1'b0;
    k = 0;
    @(negedge clk_sys_in);
    chk({7'h00, host_busy}, 8'h01);
    while (done !== 1'b1 && k < 40000)
    begin
      @(negedge clk_sys_in);
      k++;
    end
    while (data_valid === 1'b1 && k < 40000)
    begin
      @(negedge clk_sys_in);
      k++;
    end
    chk(8'(k >= 40000), 8'h00);
    chk({6'h00, host_busy, dev_busy}, 8'h00);
    chk(8'(rx_q.size()), ser ? 8'h10 : n);
    chk(dev_opcode, ser ? 8'h4B : 8'h5A);
    chk({7'h00, link.miso_oe_n}, 8'h01);
    for (int i = 0; i < rx_q.size(); i++)
      chk(rx_q[i], exp_byte(ser, i, 24'(a + i)));
  endtask : run_read

  task automatic test_done();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  initial
  begin
    #1_200_000;
    miscompares++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    test_done();
  end

  initial
  begin
    void'($urandom(32'h92e55631));
    repeat (4) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    run_read(1'b1, 24'h000000, 8'h00);
    run_read(1'b1, 24'h000000, 8'h00);
    run_read(1'b0, 24'h000000, 8'h40);
    run_read(1'b0, 24'h000030, 8'h0C);
    chk({7'h00, wait_ok(rx_q[8])}, 8'h01);
    chk({7'h00, wait_ok(rx_q[10])}, 8'h01);
    chk({7'h00, mode_ok(rx_q[8])}, 8'h01);
    chk({7'h00, mode_ok(rx_q[10])}, 8'h00);
    run_read(1'b0, 24'h000000, 8'h00);
    run_read(1'b0, 24'hFFFFFE, 8'h04);
    ready_pct = 5;
    run_read(1'b0, 24'h00002C, 8'h14);
    for (int r = 0; r < 6; r++)
    begin
      ready_pct = $urandom_range(90, 10);
      run_read(1'($urandom_range(1)), 24'($urandom_range(63)), 8'($urandom_range(24, 1)));
    end
    test_done();
  end
endmodule : unique_id_and_sfdp_read_tb
`default_nettype wire
